// ==== core/orw_ctrl.v ====
// Reset, interrupt, watchdog and option control with APB registers
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "orw_defs.vh"

// Summary of operation
// - Reset on power-on, pin, watchdog, illegal address
// - No internal low-voltage reset source
// - Five interrupt sources raise interrupts
// - Port A interrupt needs option bit 2
// - Option bit 1 selects external sensitivity
// - Watchdog runs only if option bit 0 set
// - Writing 0 to clear bit 0 restarts watchdog
// - Rate select bits pick watchdog timeout
// - Option bit order from delay down to enable
// - Pulldown inhibit bit disables pin pulldowns
// - Stop-to-wait turns stop into wait
// - Stabilise 4064 cycles, or 128 when short
// - Memory security refuses external array access
// - Oscillator resistor bit switches feedback resistor
// - Sensitivity is edge-and-level or edge only
module orw_ctrl #(
	parameter WDOG_BASE = `ORW_WDOG_BASE,
	parameter [`ORW_STAB_W-1:0] STAB_LONG = `ORW_STAB_LONG,
	parameter [`ORW_STAB_W-1:0] STAB_SHORT = `ORW_STAB_SHORT
)(
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`ORW_AW-1:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	output wire irq,
	input wire rst_pin_n,
	input wire irq_pin_n,
	input wire [3:0] port_a_low_pins,
	input wire swi_req,
	input wire timer_ovf,
	input wire rti_tick,
	input wire illegal_addr,
	input wire stop_req,
	input wire [7:0] option_nv,
	input wire ext_mem_req,
	output wire ext_mem_grant,
	output wire ext_mem_deny,
	output wire sys_rst_n,
	output wire cpu_run,
	output wire clk_run,
	output wire wait_mode,
	output wire stop_mode,
	output wire pulldown_en,
	output wire osc_res_en
);
	// Address match against a register index
	function hit;
		input [`ORW_AW-1:0] a;
		input [11:0] idx;
		begin
			hit = (a[`ORW_AW-1:2] == idx);
		end
	endfunction

	// Stabilisation length chosen by the short delay field
	function [`ORW_STAB_W-1:0] stab_len;
		input short;
		begin
			stab_len = short ? (STAB_SHORT - `ORW_STAB_ONE) : (STAB_LONG - `ORW_STAB_ONE);
		end
	endfunction

	// Pin synchronisers: reset pin, interrupt pin, four port A pins
	reg [5:0] sync1_ff;
	reg [5:0] sync2_ff;
	reg [5:0] prev_ff;

	// Option register and mode state
	reg [7:0] option_register_ff;
	reg opt_loaded_ff;
	reg [1:0] state_ff;
	reg [1:0] nxt_state;
	reg [`ORW_STAB_W-1:0] stab_ff;
	reg [`ORW_STAB_W-1:0] nxt_stab;
	reg from_rst_ff;
	reg nxt_from_rst;

	// Software visible registers
	reg [1:0] tsc_ff;
	reg [1:0] nxt_tsc;
	reg [`ORW_IW-1:0] ist_ff;
	reg [`ORW_IW-1:0] nxt_ist;
	reg [`ORW_IW-1:0] imsk_ff;
	reg [`ORW_IW-1:0] nxt_imsk;
	reg [3:0] rcause_ff;
	reg [3:0] nxt_rcause;

	// Bus answer and outputs
	reg [31:0] prdata_ff;
	reg pready_ff;
	reg pslverr_ff;
	reg irq_ff;
	reg grant_ff;
	reg deny_ff;
	reg sys_rst_n_ff;
	reg cpu_run_ff;
	reg clk_run_ff;
	reg wait_ff;
	reg stop_ff;
	reg pulldown_en_ff;
	reg osc_res_en_ff;

	wire pin_rst_w;
	wire irq_low_w;
	wire irq_fall_w;
	wire [3:0] pa_w;
	wire acc_w;
	wire done_w;
	wire wr_w;
	wire rd_w;
	wire mapped_w;
	wire wd_clr_w;
	wire wd_en_w;
	wire wd_to_w;
	wire rst_req_w;
	wire wake_w;
	wire [`ORW_IW-1:0] ev_w;
	reg [31:0] rdata;

	// Two flops per pin plus prev_ff; logic reads the second stage and prev_ff
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_ff <= 6'h30; // Idle levels: reset and irq pins high, port A low
			sync2_ff <= 6'h30;
			prev_ff <= 6'h30;
		end
		else
		begin
			sync1_ff <= {rst_pin_n, irq_pin_n, port_a_low_pins};
			sync2_ff <= sync1_ff;
			prev_ff <= sync2_ff;
		end
	end

	assign pin_rst_w = ~sync2_ff[5];
	assign irq_low_w = ~sync2_ff[4];
	assign irq_fall_w = prev_ff[4] & ~sync2_ff[4];
	assign pa_w = sync2_ff[3:0];

	// Power-on comes from presetn itself; no supply monitor here
	assign rst_req_w = pin_rst_w | wd_to_w | illegal_addr;

	// Option contents captured once after release, never written
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			option_register_ff <= 8'h00;
			opt_loaded_ff <= 1'b0;
		end
		else if (!opt_loaded_ff)
		begin
			option_register_ff <= option_nv;
			opt_loaded_ff <= 1'b1;
		end
	end

	// APB: one wait state, answer registered in the first access cycle
	assign acc_w = psel & penable;
	assign done_w = acc_w & pready_ff;
	assign wr_w = done_w & pwrite;
	assign rd_w = done_w & ~pwrite;
	assign mapped_w = hit(paddr, `ORW_IDX_WDCLR) | hit(paddr, `ORW_IDX_OPT) |
		hit(paddr, `ORW_IDX_TSC) | hit(paddr, `ORW_IDX_IST) |
		hit(paddr, `ORW_IDX_IMSK) | hit(paddr, `ORW_IDX_RCAUSE);

	// Read mux; the clear register is write-only and reads zero
	always @*
	begin
		rdata = 32'h00000000;
		if (hit(paddr, `ORW_IDX_OPT))
			rdata[7:0] = option_register_ff;
		else if (hit(paddr, `ORW_IDX_TSC))
			rdata[1:0] = tsc_ff;
		else if (hit(paddr, `ORW_IDX_IST))
			rdata[`ORW_IW-1:0] = ist_ff;
		else if (hit(paddr, `ORW_IDX_IMSK))
			rdata[`ORW_IW-1:0] = imsk_ff;
		else if (hit(paddr, `ORW_IDX_RCAUSE))
			rdata[3:0] = rcause_ff;
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h00000000;
		end
		else if (acc_w && !pready_ff)
		begin
			pready_ff <= 1'b1;
			pslverr_ff <= ~mapped_w;
			prdata_ff <= pwrite ? 32'h00000000 : rdata;
		end
		else
		begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end
	end

	// Watchdog restart by writing zero to the clear bit
	assign wd_clr_w = (wr_w & hit(paddr, `ORW_IDX_WDCLR) &
		(pwdata[`ORW_WDCLR_BIT] == `ORW_WDCLR_VAL)) | rst_req_w;
	// Counts only when enabled by option and the core is clocked
	assign wd_en_w = opt_loaded_ff & option_register_ff[`ORW_OPT_WDEN] &
		(state_ff == `ORW_ST_RUN || state_ff == `ORW_ST_WAIT);

	orw_wdog #(
		.BASE(WDOG_BASE)
	) u_wdog (
		.pclk(pclk),
		.presetn(presetn),
		.en(wd_en_w),
		.clr(wd_clr_w),
		.rate(tsc_ff),
		.timeout(wd_to_w)
	);

	// Interrupt events; external sensitivity from option bit 1
	// Edge always counts; level adds held-low assertion
	assign ev_w[`ORW_IST_SWI] = swi_req;
	assign ev_w[`ORW_IST_EXT] = irq_fall_w | (option_register_ff[`ORW_OPT_SENS] & irq_low_w);
	assign ev_w[`ORW_IST_PORTA] = option_register_ff[`ORW_OPT_PAIE] & (|pa_w);
	assign ev_w[`ORW_IST_TOV] = timer_ovf;
	assign ev_w[`ORW_IST_RTI] = rti_tick;

	// Software registers; a new event wins over a read clear
	always @*
	begin
		nxt_tsc = tsc_ff;
		nxt_imsk = imsk_ff;
		nxt_ist = ist_ff;
		nxt_rcause = rcause_ff;
		// Clear only what the read reported, so a bit set after the capture is kept
		if (rd_w && hit(paddr, `ORW_IDX_IST))
			nxt_ist = ist_ff & ~prdata_ff[`ORW_IW-1:0];
		if (rd_w && hit(paddr, `ORW_IDX_RCAUSE))
			nxt_rcause = rcause_ff & ~prdata_ff[3:0];
		if (wr_w && hit(paddr, `ORW_IDX_TSC))
			nxt_tsc = {pwdata[`ORW_TSC_RATE_HI], pwdata[`ORW_TSC_RATE_LO]};
		if (wr_w && hit(paddr, `ORW_IDX_IMSK))
			nxt_imsk = pwdata[`ORW_IW-1:0];
		// Internal reset returns control state to its reset values
		if (rst_req_w)
		begin
			nxt_tsc = `ORW_TSC_RST;
			nxt_imsk = `ORW_IST_RST;
			nxt_ist = `ORW_IST_RST;
		end
		else
			nxt_ist = nxt_ist | ev_w;
		nxt_rcause[`ORW_RC_PIN] = nxt_rcause[`ORW_RC_PIN] | pin_rst_w;
		nxt_rcause[`ORW_RC_WDOG] = nxt_rcause[`ORW_RC_WDOG] | wd_to_w;
		nxt_rcause[`ORW_RC_ILL] = nxt_rcause[`ORW_RC_ILL] | illegal_addr;
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tsc_ff <= `ORW_TSC_RST;
			imsk_ff <= `ORW_IST_RST;
			ist_ff <= `ORW_IST_RST;
			rcause_ff <= `ORW_RC_RST;
			irq_ff <= 1'b0;
		end
		else
		begin
			tsc_ff <= nxt_tsc;
			imsk_ff <= nxt_imsk;
			ist_ff <= nxt_ist;
			rcause_ff <= nxt_rcause;
			irq_ff <= |(nxt_ist & nxt_imsk);
		end
	end

	// Any unmasked pending interrupt ends wait or stop
	assign wake_w = |(ist_ff & imsk_ff);

	// Mode machine: stabilise, run, wait, stop
	always @*
	begin
		nxt_state = state_ff;
		nxt_stab = stab_ff;
		nxt_from_rst = from_rst_ff;
		if (!opt_loaded_ff)
		begin
			// Length not known until the option byte arrives
			nxt_stab = stab_len(option_nv[`ORW_OPT_SHORT]);
		end
		else if (rst_req_w)
		begin
			nxt_state = `ORW_ST_STAB;
			nxt_stab = stab_len(option_register_ff[`ORW_OPT_SHORT]);
			nxt_from_rst = 1'b1;
		end
		else
		begin
			case (state_ff)
				`ORW_ST_STAB:
				begin
					if (stab_ff == {`ORW_STAB_W{1'b0}})
					begin
						nxt_state = `ORW_ST_RUN;
						nxt_from_rst = 1'b0;
					end
					else
						nxt_stab = stab_ff - `ORW_STAB_ONE;
				end
				`ORW_ST_RUN:
				begin
					if (stop_req && option_register_ff[`ORW_OPT_S2W])
						nxt_state = `ORW_ST_WAIT;
					else if (stop_req)
						nxt_state = `ORW_ST_STOP;
				end
				`ORW_ST_WAIT:
				begin
					if (wake_w)
						nxt_state = `ORW_ST_RUN;
				end
				`ORW_ST_STOP:
				begin
					// Oscillator restarts, so stabilise again
					if (wake_w)
					begin
						nxt_state = `ORW_ST_STAB;
						nxt_stab = stab_len(option_register_ff[`ORW_OPT_SHORT]);
					end
				end
				default:
				begin
					nxt_state = `ORW_ST_STAB;
					nxt_stab = stab_len(option_register_ff[`ORW_OPT_SHORT]);
					nxt_from_rst = 1'b1;
				end
			endcase
		end
	end

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_ff <= `ORW_ST_STAB;
			stab_ff <= `ORW_STAB_LONG;
			from_rst_ff <= 1'b1;
			sys_rst_n_ff <= 1'b0;
			cpu_run_ff <= 1'b0;
			clk_run_ff <= 1'b1;
			wait_ff <= 1'b0;
			stop_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			stab_ff <= nxt_stab;
			from_rst_ff <= nxt_from_rst;
			sys_rst_n_ff <= ~nxt_from_rst;
			cpu_run_ff <= (nxt_state == `ORW_ST_RUN);
			clk_run_ff <= (nxt_state != `ORW_ST_STOP);
			wait_ff <= (nxt_state == `ORW_ST_WAIT);
			stop_ff <= (nxt_state == `ORW_ST_STOP);
		end
	end

	// Option driven controls; until loaded, access is refused
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			grant_ff <= 1'b0;
			deny_ff <= 1'b0;
			pulldown_en_ff <= 1'b0;
			osc_res_en_ff <= 1'b0;
		end
		else
		begin
			grant_ff <= ext_mem_req & opt_loaded_ff & ~option_register_ff[`ORW_OPT_SEC];
			deny_ff <= ext_mem_req & ~(opt_loaded_ff & ~option_register_ff[`ORW_OPT_SEC]);
			pulldown_en_ff <= opt_loaded_ff & ~option_register_ff[`ORW_OPT_PDINH];
			osc_res_en_ff <= opt_loaded_ff & option_register_ff[`ORW_OPT_INTERNAL_OSC_RESISTOR];
		end
	end

	// Every output straight from a flop
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign irq = irq_ff;
	assign ext_mem_grant = grant_ff;
	assign ext_mem_deny = deny_ff;
	assign sys_rst_n = sys_rst_n_ff;
	assign cpu_run = cpu_run_ff;
	assign clk_run = clk_run_ff;
	assign wait_mode = wait_ff;
	assign stop_mode = stop_ff;
	assign pulldown_en = pulldown_en_ff;
	assign osc_res_en = osc_res_en_ff;
endmodule // orw_ctrl

`default_nettype wire

// ==== core/orw_defs.vh ====
// Constants for the option, reset and watchdog control block
`ifndef ORW_DEFS_VH
`define ORW_DEFS_VH

// Register indices; the APB byte address is four times the index
`define ORW_IDX_WDCLR 12'h7F0
`define ORW_IDX_OPT 12'h7F1
`define ORW_IDX_TSC 12'h7F2
`define ORW_IDX_IST 12'h7F3
`define ORW_IDX_IMSK 12'h7F4
`define ORW_IDX_RCAUSE 12'h7F5
`define ORW_AW 14

// Option register fields
`define ORW_OPT_WDEN 0
`define ORW_OPT_SENS 1
`define ORW_OPT_PAIE 2
`define ORW_OPT_PDINH 3
`define ORW_OPT_S2W 4
`define ORW_OPT_INTERNAL_OSC_RESISTOR 5
`define ORW_OPT_SEC 6
`define ORW_OPT_SHORT 7

// Watchdog clear register: the clear bit and the value that clears
`define ORW_WDCLR_BIT 0
`define ORW_WDCLR_VAL 1'h0

// Timer status and control: rate select fields
`define ORW_TSC_RATE_LO 0
`define ORW_TSC_RATE_HI 1
`define ORW_TSC_RST 2'h0

// Interrupt status and mask layout
`define ORW_IW 5
`define ORW_IST_SWI 0
`define ORW_IST_EXT 1
`define ORW_IST_PORTA 2
`define ORW_IST_TOV 3
`define ORW_IST_RTI 4
`define ORW_IST_RST 5'h00

// Reset cause layout; power-on is recorded by the asynchronous reset
`define ORW_RC_POR 0
`define ORW_RC_PIN 1
`define ORW_RC_WDOG 2
`define ORW_RC_ILL 3
`define ORW_RC_RST 4'h1

// Oscillator stabilisation, in bus cycles
`define ORW_STAB_W 12
`define ORW_STAB_LONG 12'hFE0
`define ORW_STAB_SHORT 12'h080
`define ORW_STAB_ONE 12'h001

// Watchdog: timeout after 2**(base + rate) cycles
`define ORW_WDOG_BASE 13

// Mode states
`define ORW_ST_STAB 2'h0
`define ORW_ST_RUN 2'h1
`define ORW_ST_WAIT 2'h2
`define ORW_ST_STOP 2'h3

`endif

// ==== core/orw_wdog.v ====
// Watchdog counter with selectable timeout period
`timescale 1ns/1ps
`default_nettype none

module orw_wdog #(
	parameter BASE = 13,
	parameter CW = BASE + 4
)(
	input wire pclk,
	input wire presetn,
	input wire en,
	input wire clr,
	input wire [1:0] rate,
	output wire timeout
);
	wire [CW-1:0] one_w;
	wire [CW-1:0] limit_w;
	reg [CW-1:0] cnt_ff;
	reg to_ff;

	// Terminal count doubles with each rate step
	assign one_w = {{(CW-1){1'b0}}, 1'b1};
	assign limit_w = (one_w << (BASE + rate)) - one_w;
	assign timeout = to_ff;

	// Clear has priority so a restart in the last cycle avoids the timeout
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_ff <= {CW{1'b0}};
			to_ff <= 1'b0;
		end
		else if (clr)
		begin
			cnt_ff <= {CW{1'b0}};
			to_ff <= 1'b0;
		end
		else if (en && cnt_ff == limit_w)
		begin
			cnt_ff <= {CW{1'b0}};
			to_ff <= 1'b1;
		end
		else if (en)
		begin
			cnt_ff <= cnt_ff + one_w;
			to_ff <= 1'b0;
		end
		else
		begin
			to_ff <= 1'b0;
		end
	end
endmodule // orw_wdog

`default_nettype wire

// ==== tb/orw_ctrl_properties.sv ====
// Concurrent checks on the ports of the option, reset and watchdog block
`timescale 1ns/1ps
`default_nettype none
`include "orw_defs.vh"

module orw_ctrl_properties #(
	parameter [`ORW_STAB_W-1:0] STAB_LONG = `ORW_STAB_LONG,
	parameter [`ORW_STAB_W-1:0] STAB_SHORT = `ORW_STAB_SHORT
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic rst_pin_n,
	input wire logic illegal_addr,
	input wire logic stop_req,
	input wire logic [7:0] option_nv,
	input wire logic ext_mem_req,
	input wire logic ext_mem_grant,
	input wire logic ext_mem_deny,
	input wire logic sys_rst_n,
	input wire logic cpu_run,
	input wire logic clk_run,
	input wire logic wait_mode,
	input wire logic pulldown_en,
	input wire logic osc_res_en
);
	logic [15:0] low_cnt_ff;
	logic por_ff;
	wire [15:0] stab_len = {4'h0, option_nv[7] ? STAB_SHORT : STAB_LONG};

	// Cycles held in reset; only the first exit after power-on is judged
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			low_cnt_ff <= 16'h0;
			por_ff <= 1'h1;
		end
		else
		begin
			low_cnt_ff <= sys_rst_n ? 16'h0 : low_cnt_ff + 16'h1;
			por_ff <= por_ff & ~sys_rst_n;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Setup cycle followed by the first access cycle
	sequence s_access;
		psel && !penable ##1 psel && penable;
	endsequence
	sequence s_stop_cmd;
		stop_req && cpu_run;
	endsequence

	property p_one_wait;
		s_access |=> pready;
	endproperty
	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	property p_err_ready;
		pslverr |-> pready;
	endproperty
	property p_illegal;
		illegal_addr |-> ##[1:3] !sys_rst_n;
	endproperty
	property p_pin;
		$fell(rst_pin_n) |-> ##[1:4] !sys_rst_n;
	endproperty
	property p_deny;
		ext_mem_req && cpu_run |=> ext_mem_deny == option_nv[6] && ext_mem_grant == !option_nv[6];
	endproperty
	property p_pin_cfg;
		cpu_run |-> pulldown_en == !option_nv[3] && osc_res_en == option_nv[5];
	endproperty
	property p_wait;
		s_stop_cmd ##0 option_nv[4] |=> wait_mode && clk_run;
	endproperty
	property p_stop;
		s_stop_cmd ##0 !option_nv[4] |=> !clk_run && !wait_mode;
	endproperty
	property p_stab;
		por_ff && $rose(sys_rst_n) |-> low_cnt_ff >= stab_len && low_cnt_ff <= stab_len + 16'h4;
	endproperty

	a_one_wait: assert property (p_one_wait) else $error("pready late");
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
	a_err_ready: assert property (p_err_ready) else $error("pslverr without pready");
	a_illegal: assert property (p_illegal) else $error("no reset on illegal access");
	a_pin: assert property (p_pin) else $error("no reset from pin");
	a_deny: assert property (p_deny) else $error("array access answer wrong");
	a_pin_cfg: assert property (p_pin_cfg) else $error("pin config wrong");
	a_wait: assert property (p_wait) else $error("stop not turned to wait");
	a_stop: assert property (p_stop) else $error("stop did not halt clocks");
	a_stab: assert property (p_stab) else $error("stabilisation length wrong");
endmodule // orw_ctrl_properties

bind orw_ctrl orw_ctrl_properties #(.STAB_LONG(STAB_LONG), .STAB_SHORT(STAB_SHORT)) i_props (.pclk, .presetn,
	.psel, .penable, .pready, .pslverr, .rst_pin_n, .illegal_addr, .stop_req, .option_nv, .ext_mem_req,
	.ext_mem_grant, .ext_mem_deny, .sys_rst_n, .cpu_run, .clk_run, .wait_mode, .pulldown_en, .osc_res_en);
`default_nettype wire

// ==== tb/test_orw_ctrl.sv ====
// Self-checking bench for the option, reset and watchdog block
`timescale 1ns/1ps
`default_nettype none
`include "orw_defs.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; $display("Error at %0t: got %h expected %h", $time, g, e); end end

module test_orw_ctrl;
	localparam WB = 8;
	localparam [11:0] SL = 12'h010;
	localparam [11:0] SS = 12'h004;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rst_pin_n = 1, irq_pin_n = 1;
	logic swi_req = 0, timer_ovf = 0, rti_tick = 0, illegal_addr = 0, stop_req = 0, ext_mem_req = 0;
	logic [13:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, d, st;
	logic [3:0] port_a_low_pins = 0;
	logic [7:0] option_nv = 0, opt, rnd;
	logic pready, pslverr, irq, ext_mem_grant, ext_mem_deny, sys_rst_n, cpu_run, clk_run, e;
	logic wait_mode, stop_mode, pulldown_en, osc_res_en;
	int fails = 0, tests_run = 0, n;

	// Short counts keep the run brief; expectations use the same values
	orw_ctrl #(.WDOG_BASE(WB), .STAB_LONG(SL), .STAB_SHORT(SS)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .rst_pin_n, .irq_pin_n, .port_a_low_pins, .swi_req,
		.timer_ovf, .rti_tick, .illegal_addr, .stop_req, .option_nv, .ext_mem_req, .ext_mem_grant, .ext_mem_deny,
		.sys_rst_n, .cpu_run, .clk_run, .wait_mode, .stop_mode, .pulldown_en, .osc_res_en);

	always #25 pclk = ~pclk;

	// One APB transfer, held until pready is sampled high
	task apb(input logic w, input logic [11:0] idx, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= {idx, 2'h0};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'h1;
		do
			@(posedge pclk);
		while (pready !== 1'h1);
		d = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	// Bounded wait for the core to run again; n holds the edges waited
	task wait_run;
		n = 0;
		while (cpu_run !== 1'h1 && n < 9000)
		begin
			@(posedge pclk);
			n++;
		end
		// A core that never resumes counts as a mismatch
		if (n >= 9000)
			fails++;
	endtask

	task print_verdict;
		if (fails == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Hang guard well beyond the expected run
	initial
	begin
		#2000000;
		fails++;
		print_verdict;
	end

	initial
	begin
		rnd = $urandom(32'h9CA0);
		for (int i = 0; i < 4; i++)
		begin
			if (i == 2)
				rnd = $urandom;
			opt = i[0] ? ~rnd : rnd;
			presetn <= 1'h0;
			option_nv <= opt;
			repeat (10) @(posedge pclk);
			presetn <= 1'h1;
			wait_run;
			`CHK(n >= (opt[7] ? SS : SL) && n <= (opt[7] ? SS : SL) + 4, 1'h1)
			apb(0, `ORW_IDX_OPT, 0);
			`CHK(d, {24'h0, opt})
			apb(1, `ORW_IDX_OPT, {24'h0, ~opt});
			apb(0, `ORW_IDX_OPT, 0);
			`CHK(d, {24'h0, opt})
			apb(0, 12'h7F6, 0);
			`CHK({e, d}, 33'h100000000)
			apb(0, `ORW_IDX_RCAUSE, 0);
			`CHK(d, 32'h1)
			`CHK({pulldown_en, osc_res_en}, {~opt[3], opt[5]})
			ext_mem_req <= 1'h1;
			repeat (2) @(posedge pclk);
			`CHK({ext_mem_deny, ext_mem_grant}, {opt[6], ~opt[6]})
			ext_mem_req <= 1'h0;
			// Stop request, then wake by an unmasked software event
			apb(1, `ORW_IDX_IMSK, 32'h1);
			stop_req <= 1'h1;
			@(posedge pclk);
			stop_req <= 1'h0;
			repeat (3) @(posedge pclk);
			`CHK({wait_mode, stop_mode, clk_run, cpu_run}, {opt[4], ~opt[4], opt[4], 1'h0})
			swi_req <= 1'h1;
			@(posedge pclk);
			swi_req <= 1'h0;
			wait_run;
			`CHK(sys_rst_n, 1'h1)
			apb(0, `ORW_IDX_IST, 0);
			`CHK(d, 32'h1)
			// All five sources at once; port pins count only when enabled
			apb(1, `ORW_IDX_IMSK, 32'h1F);
			st = 32'h1B | {29'h0, opt[2], 2'h0};
			swi_req <= 1'h1;
			timer_ovf <= 1'h1;
			rti_tick <= 1'h1;
			irq_pin_n <= 1'h0;
			port_a_low_pins <= 4'h1 << rnd[1:0];
			@(posedge pclk);
			swi_req <= 1'h0;
			timer_ovf <= 1'h0;
			rti_tick <= 1'h0;
			repeat (4) @(posedge pclk);
			`CHK(irq, 1'h1)
			apb(0, `ORW_IDX_IST, 0);
			`CHK(d, st)
			apb(1, `ORW_IDX_IMSK, 32'h0);
			apb(0, `ORW_IDX_IST, 0);
			apb(0, `ORW_IDX_IST, 0);
			`CHK(d, {29'h0, opt[2], opt[1], 1'h0})
			`CHK(irq, 1'h0)
			irq_pin_n <= 1'h1;
			port_a_low_pins <= 4'h0;
			repeat (4) @(posedge pclk);
			apb(0, `ORW_IDX_IST, 0);
			// Each rate: no reset just before the period, reset just after only if option bit 0 is set
			for (int r = 0; r < 4; r++)
			begin
				apb(1, `ORW_IDX_TSC, r);
				apb(1, `ORW_IDX_WDCLR, 32'h0);
				apb(1, `ORW_IDX_WDCLR, 32'h1); // writing a one must not restart
				repeat ((1 << (WB + r)) - 12) @(posedge pclk);
				`CHK(sys_rst_n, 1'h1)
				repeat (12) @(posedge pclk);
				`CHK(sys_rst_n, ~opt[0])
				wait_run;
				apb(0, `ORW_IDX_RCAUSE, 0);
				`CHK(d, {29'h0, opt[0], 2'h0})
			end
			// Pin reset, then illegal access
			for (int k = 0; k < 2; k++)
			begin
				illegal_addr <= k[0];
				rst_pin_n <= k[0];
				repeat (3) @(posedge pclk);
				illegal_addr <= 1'h0;
				rst_pin_n <= 1'h1;
				repeat (6) @(posedge pclk);
				wait_run;
				apb(0, `ORW_IDX_RCAUSE, 0);
				`CHK(d, k ? 32'h8 : 32'h2)
			end
		end
		print_verdict;
	end
endmodule // test_orw_ctrl
`default_nettype wire
